//--- core/kxs_pkg.sv
package kxs_pkg;

  // column geometry
  localparam int           LANES          = 4;
  localparam int           LANE_W         = 8;
  localparam int           REG_W          = 16;
  localparam int           PAT_W          = 32;
  localparam int           DEVAD_W        = 5;
  localparam int           ADDR_W         = 16;

  // management device and register offsets
  localparam logic [4:0]   MGMT_DEVAD     = 5'h01;
  localparam logic [15:0]  ADDR_LANE2_EOP = 16'h8012;
  localparam logic [15:0]  ADDR_LANE3_EOP = 16'h8013;
  localparam logic [15:0]  ADDR_TX_DROP   = 16'h8014;
  localparam logic [15:0]  ADDR_TX_INS    = 16'h8015;
  localparam logic [15:0]  ADDR_RX_DROP   = 16'h8016;
  localparam logic [15:0]  ADDR_RX_INS    = 16'h8017;
  localparam logic [15:0]  ADDR_STATUS    = 16'h8018;
  localparam logic [15:0]  ADDR_PAT_HIGH  = 16'h8019;
  localparam logic [15:0]  ADDR_PAT_LOW   = 16'h801a;

  // reset values
  localparam logic [15:0]  CNT_RESET      = 16'hfffd;
  localparam logic [15:0]  PAT_HIGH_RESET = 16'hffff;
  localparam logic [31:0]  PAT_RESET      = {PAT_HIGH_RESET, CNT_RESET};
  localparam logic [15:0]  STATUS_RESET   = 16'h0000;
  localparam logic [15:0]  READ_ZERO      = 16'h0000;

  // status field positions
  localparam int           SYNC_BIT       = 15;
  localparam int           START_BIT      = 5;
  localparam int           TERM_BIT       = 4;
  localparam int           LANE_FLAG_LSB  = 0;

  // counter slots for the 16-bit counters
  localparam int           CNT16_NUM      = 6;
  localparam int           IDX_LANE2_EOP  = 0;
  localparam int           IDX_LANE3_EOP  = 1;
  localparam int           IDX_TX_DROP    = 2;
  localparam int           IDX_TX_INS     = 3;
  localparam int           IDX_RX_DROP    = 4;
  localparam int           IDX_RX_INS     = 5;

  // control codes seen on the parallel side
  localparam logic [7:0]   CODE_IDLE      = 8'h07;
  localparam logic [7:0]   CODE_K         = 8'hbc;
  localparam logic [7:0]   CODE_A         = 8'h7c;
  localparam logic [7:0]   CODE_R         = 8'h1c;
  localparam logic [7:0]   CODE_SEQ       = 8'h9c;
  localparam logic [7:0]   CODE_START     = 8'hfb;
  localparam logic [7:0]   CODE_TERM      = 8'hfd;
  localparam logic [7:0]   CODE_ERROR     = 8'hfe;

  typedef logic [15:0] kxs_word_type;

  function automatic logic [7:0] kxs_lane_byte(input logic [31:0] data, input int lane);
    return data[lane*LANE_W +: LANE_W];
  endfunction

  function automatic logic kxs_ctrl_ok(input logic [7:0] code);
    return (code == CODE_IDLE) || (code == CODE_K) || (code == CODE_A) ||
           (code == CODE_R) || (code == CODE_SEQ) || (code == CODE_START) ||
           (code == CODE_TERM) || (code == CODE_ERROR);
  endfunction

endpackage

//--- core/kxs_cnt_if.sv
`timescale 1ns/1ps
interface kxs_cnt_if #(parameter int W = 16);
  logic         inc;
  logic [W-1:0] clr_mask;
  logic [W-1:0] value;
  modport owner (input inc, input clr_mask, output value);
  modport user  (output inc, output clr_mask, input value);
endinterface

//--- core/kxs_sat_counter.sv
`timescale 1ns/1ps
module kxs_sat_counter #(
  parameter int           W     = 16,
  parameter logic [W-1:0] RESET = '0
) (
  input  wire logic  mclk,  // core clock
  input  wire logic  rst_n, // synchronised reset, active low
  kxs_cnt_if.owner   cnt    // event, clear mask, count value
);
  logic [W-1:0] value_reg;
  logic [W-1:0] value_next;
  logic [W-1:0] base;

  always_comb begin
    base       = value_reg & ~cnt.clr_mask;
    value_next = base;
    if (cnt.inc && (base != {W{1'b1}})) begin
      value_next = base + W'(1);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      value_reg <= RESET;
    end else begin
      value_reg <= value_next;
    end
  end

  assign cnt.value = value_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  AST_CNT_SATURATES: assert property (
    (value_reg == {W{1'b1}}) && (cnt.clr_mask == '0) |=> value_reg == {W{1'b1}})
    else $error("counter left its maximum without a clear");

  AST_CNT_EVENT_KEPT: assert property (
    cnt.inc && (cnt.clr_mask != '0) && ((value_reg & ~cnt.clr_mask) != {W{1'b1}})
    |=> value_reg == ($past(value_reg) & ~$past(cnt.clr_mask)) + W'(1))
    else $error("event during clear was lost");

  AST_CNT_COUNTS: assert property (
    cnt.inc && (cnt.clr_mask == '0) && (value_reg != {W{1'b1}})
    |=> value_reg == $past(value_reg) + W'(1))
    else $error("counter did not advance on event");
endmodule

//--- core/kxs_error_stats.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Lane 2 terminate errs if lane 3 lacks /K/ or next column isn't all K/A.
// - Lane 3 terminate errs if the next column is neither all /K/ nor all /A/.
// - End-of-packet counters return their value on read, then clear to zero.
// - Transmit rate compensation idle drops counted in 16 bits, clear on read.
// - Transmit rate compensation idle inserts counted in 16 bits, clear on read.
// - Receive rate compensation idle drops counted in 16 bits, clear on read.
// - Receive rate compensation idle inserts counted in 16 bits, clear on read.
// - Status bit 15 shows transmit test pattern sync, read only.
// - Status bit 5 set on an invalid start column.
// - Status bit 4 set on an invalid terminate column.
// - Status bits 0 to 3 latch invalid characters per lane.
// - Upper half of 32-bit pattern error counter readable, clears on read.
// - Lower half of pattern error counter at next register, clears on read.
module kxs_error_stats (
  input  wire logic                                    mclk,             // core clock
  input  wire logic                                    resetn,           // async reset, active low
  input  wire logic [kxs_pkg::LANES*kxs_pkg::LANE_W-1:0] xgmii_data,     // one column per clock
  input  wire logic [kxs_pkg::LANES-1:0]               xgmii_ctrl,       // control flag per lane
  input  wire logic                                    tx_idle_drop,     // tx idle deleted, pulse
  input  wire logic                                    tx_idle_insert,   // tx idle added, pulse
  input  wire logic                                    rx_idle_drop,     // rx idle deleted, pulse
  input  wire logic                                    rx_idle_insert,   // rx idle added, pulse
  input  wire logic                                    tx_pattern_sync,  // checker in sync, level
  input  wire logic                                    tx_pattern_error, // pattern error, pulse
  input  wire logic                                    mgmt_rd_en,       // read strobe
  input  wire logic [kxs_pkg::DEVAD_W-1:0]             mgmt_devad,       // device address
  input  wire logic [kxs_pkg::ADDR_W-1:0]              mgmt_addr,        // register address
  output      logic [kxs_pkg::REG_W-1:0]               mgmt_rdata,       // read data
  output      logic                                    mgmt_rvalid       // read data valid, pulse
);
  import kxs_pkg::*;

  logic                rst_meta_reg;
  logic                rst_sync_reg;
  logic                rst_n;

  logic [LANES-1:0]    is_term;
  logic [LANES-1:0]    is_start;
  logic [LANES-1:0]    is_k;
  logic [LANES-1:0]    is_a;
  logic [LANES-1:0]    bad_char;
  logic                next_ka;
  logic                start_bad;
  logic                term_bad;

  logic                term2_pend_reg;
  logic                lane3_notk_reg;
  logic                term3_pend_reg;
  logic                eop2_evt;
  logic                eop3_evt;

  logic [CNT16_NUM-1:0] inc_vec;
  logic [CNT16_NUM-1:0] clr_sel;
  logic                 clr_pat_hi;
  logic                 clr_pat_lo;
  logic                 status_rd;
  logic                 rd_hit;
  kxs_word_type         rd_val;
  kxs_word_type         cnt_val [CNT16_NUM];
  logic [PAT_W-1:0]     pat_val;

  kxs_word_type         flag_set;
  kxs_word_type         flags_reg;
  kxs_word_type         flags_next;
  kxs_word_type         status_val;

  kxs_word_type         mgmt_rdata_reg;
  logic                 mgmt_rvalid_reg;

  // reset release through two stages
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_sync_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_sync_reg <= rst_meta_reg;
    end
  end

  assign rst_n = rst_sync_reg;

  // per-lane column decode
  always_comb begin
    for (int i = 0; i < LANES; i++) begin
      is_term[i]  = xgmii_ctrl[i] && (kxs_lane_byte(xgmii_data, i) == CODE_TERM);
      is_start[i] = xgmii_ctrl[i] && (kxs_lane_byte(xgmii_data, i) == CODE_START);
      is_k[i]     = xgmii_ctrl[i] && (kxs_lane_byte(xgmii_data, i) == CODE_K);
      is_a[i]     = xgmii_ctrl[i] && (kxs_lane_byte(xgmii_data, i) == CODE_A);
      bad_char[i] = xgmii_ctrl[i] && !kxs_ctrl_ok(kxs_lane_byte(xgmii_data, i));
    end
  end

  assign next_ka = (&is_k) || (&is_a);

  // start only in lane 0, rest of the column data
  assign start_bad = (|is_start) && (!is_start[0] || (|xgmii_ctrl[LANES-1:1]));

  // terminate must be single with only data before it
  always_comb begin
    term_bad = (|is_term) && !$onehot(is_term);
    for (int i = 1; i < LANES; i++) begin
      for (int j = 0; j < i; j++) begin
        if (is_term[i] && xgmii_ctrl[j]) begin
          term_bad = 1'b1;
        end
      end
    end
  end

  // hold terminate context for the following column
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      term2_pend_reg <= 1'b0;
      lane3_notk_reg <= 1'b0;
      term3_pend_reg <= 1'b0;
    end else begin
      term2_pend_reg <= is_term[2];
      lane3_notk_reg <= !is_k[3];
      term3_pend_reg <= is_term[3];
    end
  end

  assign eop2_evt = term2_pend_reg && (lane3_notk_reg || !next_ka);
  assign eop3_evt = term3_pend_reg && !next_ka;

  always_comb begin
    inc_vec                = '0;
    inc_vec[IDX_LANE2_EOP] = eop2_evt;
    inc_vec[IDX_LANE3_EOP] = eop3_evt;
    inc_vec[IDX_TX_DROP]   = tx_idle_drop;
    inc_vec[IDX_TX_INS]    = tx_idle_insert;
    inc_vec[IDX_RX_DROP]   = rx_idle_drop;
    inc_vec[IDX_RX_INS]    = rx_idle_insert;
  end

  kxs_cnt_if #(.W(REG_W)) c16_if [CNT16_NUM] ();
  kxs_cnt_if #(.W(PAT_W)) pat_if ();

  for (genvar g = 0; g < CNT16_NUM; g++) begin : g_cnt16
    assign c16_if[g].inc      = inc_vec[g];
    assign c16_if[g].clr_mask = {REG_W{clr_sel[g]}};
    assign cnt_val[g]         = c16_if[g].value;

    kxs_sat_counter #(
      .W     (REG_W),
      .RESET (CNT_RESET)
    ) u_cnt (
      .mclk  (mclk),
      .rst_n (rst_n),
      .cnt   (c16_if[g])
    );
  end

  assign pat_if.inc      = tx_pattern_error;
  assign pat_if.clr_mask = {{REG_W{clr_pat_hi}}, {REG_W{clr_pat_lo}}};
  assign pat_val         = pat_if.value;

  kxs_sat_counter #(
    .W     (PAT_W),
    .RESET (PAT_RESET)
  ) u_pat_cnt (
    .mclk  (mclk),
    .rst_n (rst_n),
    .cnt   (pat_if)
  );

  always_comb begin
    flag_set            = STATUS_RESET;
    flag_set[START_BIT] = start_bad;
    flag_set[TERM_BIT]  = term_bad;
    flag_set[LANE_FLAG_LSB +: LANES] = bad_char;
  end

  assign flags_next = flag_set | (flags_reg & ~{REG_W{status_rd}});

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags_reg <= STATUS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_comb begin
    status_val           = flags_reg;
    status_val[SYNC_BIT] = tx_pattern_sync;
  end

  assign rd_hit = mgmt_rd_en && (mgmt_devad == MGMT_DEVAD);

  // read selects value and clears it
  always_comb begin
    rd_val     = READ_ZERO;
    clr_sel    = '0;
    clr_pat_hi = 1'b0;
    clr_pat_lo = 1'b0;
    status_rd  = 1'b0;
    if (!rd_hit) begin
      rd_val = READ_ZERO;
    end else if (mgmt_addr == ADDR_LANE2_EOP) begin
      rd_val                 = cnt_val[IDX_LANE2_EOP];
      clr_sel[IDX_LANE2_EOP] = 1'b1;
    end else if (mgmt_addr == ADDR_LANE3_EOP) begin
      rd_val                 = cnt_val[IDX_LANE3_EOP];
      clr_sel[IDX_LANE3_EOP] = 1'b1;
    end else if (mgmt_addr == ADDR_TX_DROP) begin
      rd_val               = cnt_val[IDX_TX_DROP];
      clr_sel[IDX_TX_DROP] = 1'b1;
    end else if (mgmt_addr == ADDR_TX_INS) begin
      rd_val              = cnt_val[IDX_TX_INS];
      clr_sel[IDX_TX_INS] = 1'b1;
    end else if (mgmt_addr == ADDR_RX_DROP) begin
      rd_val               = cnt_val[IDX_RX_DROP];
      clr_sel[IDX_RX_DROP] = 1'b1;
    end else if (mgmt_addr == ADDR_RX_INS) begin
      rd_val              = cnt_val[IDX_RX_INS];
      clr_sel[IDX_RX_INS] = 1'b1;
    end else if (mgmt_addr == ADDR_STATUS) begin
      rd_val    = status_val;
      status_rd = 1'b1;
    end else if (mgmt_addr == ADDR_PAT_HIGH) begin
      rd_val     = pat_val[PAT_W-1:REG_W];
      clr_pat_hi = 1'b1;
    end else if (mgmt_addr == ADDR_PAT_LOW) begin
      rd_val     = pat_val[REG_W-1:0];
      clr_pat_lo = 1'b1;
    end else begin
      rd_val = READ_ZERO;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rdata_reg <= READ_ZERO;
    end else if (mgmt_rd_en) begin
      mgmt_rdata_reg <= rd_val;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mgmt_rvalid_reg <= 1'b0;
    end else begin
      mgmt_rvalid_reg <= mgmt_rd_en;
    end
  end

  assign mgmt_rdata  = mgmt_rdata_reg;
  assign mgmt_rvalid = mgmt_rvalid_reg;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence s_term2_no_k;
    is_term[2] && !is_k[3];
  endsequence

  sequence s_term3_bad_next;
    is_term[3] ##1 (!next_ka && !clr_sel[IDX_LANE3_EOP] && cnt_val[IDX_LANE3_EOP] != 16'hffff);
  endsequence

  sequence s_read_lane2;
    rd_hit && (mgmt_addr == ADDR_LANE2_EOP) && !eop2_evt;
  endsequence

  AST_LANE2_EOP: assert property (
    s_term2_no_k |=> eop2_evt)
    else $error("lane 2 terminate without lane 3 idle not flagged");

  AST_LANE3_EOP: assert property (
    s_term3_bad_next |=> cnt_val[IDX_LANE3_EOP] == $past(cnt_val[IDX_LANE3_EOP]) + 16'h0001)
    else $error("lane 3 end error not counted");

  AST_READ_CLEAR: assert property (
    s_read_lane2 |=> (cnt_val[IDX_LANE2_EOP] == 16'h0000) &&
                     (mgmt_rdata == $past(cnt_val[IDX_LANE2_EOP])) && mgmt_rvalid)
    else $error("end counter read did not return and clear");

  AST_TX_DROP: assert property (
    tx_idle_drop && !clr_sel[IDX_TX_DROP] && cnt_val[IDX_TX_DROP] != 16'hffff
    |=> cnt_val[IDX_TX_DROP] == $past(cnt_val[IDX_TX_DROP]) + 16'h0001)
    else $error("tx drop not counted");

  AST_TX_INS: assert property (
    tx_idle_insert && rd_hit && (mgmt_addr == ADDR_TX_INS)
    |=> cnt_val[IDX_TX_INS] == 16'h0001)
    else $error("tx insert during read lost");

  AST_RX_DROP: assert property (
    !rx_idle_drop && rd_hit && (mgmt_addr == ADDR_RX_DROP)
    |=> cnt_val[IDX_RX_DROP] == 16'h0000)
    else $error("rx drop counter not cleared by read");

  AST_RX_INS: assert property (
    rx_idle_insert && !clr_sel[IDX_RX_INS] && cnt_val[IDX_RX_INS] != 16'hffff
    |=> cnt_val[IDX_RX_INS] == $past(cnt_val[IDX_RX_INS]) + 16'h0001)
    else $error("rx insert not counted");

  AST_SYNC_BIT: assert property (
    rd_hit && (mgmt_addr == ADDR_STATUS) |=> mgmt_rdata[SYNC_BIT] == $past(tx_pattern_sync))
    else $error("sync bit does not follow checker");

  AST_START_FLAG: assert property (
    is_start[1] ##1 !status_rd ##1 (rd_hit && (mgmt_addr == ADDR_STATUS)) |=> mgmt_rdata[START_BIT])
    else $error("invalid start not reported");

  AST_TERM_FLAG: assert property (
    (is_term[0] && is_term[1]) |=> flags_reg[TERM_BIT])
    else $error("invalid terminate not latched");

  AST_LANE_FLAG: assert property (
    bad_char[3] ##1 !status_rd |=> flags_reg[LANE_FLAG_LSB + 3])
    else $error("lane 3 flag not held");

  AST_PAT_HIGH: assert property (
    rd_hit && (mgmt_addr == ADDR_PAT_HIGH) && !tx_pattern_error
    |=> (mgmt_rdata == $past(pat_val[PAT_W-1:REG_W])) && (pat_val[PAT_W-1:REG_W] == 16'h0000))
    else $error("pattern high half read failed");

  AST_PAT_LOW: assert property (
    rd_hit && (mgmt_addr == ADDR_PAT_LOW) && !tx_pattern_error
    |=> (mgmt_rdata == $past(pat_val[REG_W-1:0])) && (pat_val[REG_W-1:0] == 16'h0000) &&
        (pat_val[PAT_W-1:REG_W] == $past(pat_val[PAT_W-1:REG_W])))
    else $error("pattern low half read failed");

  AST_FLAG_CLEAR: assert property (
    status_rd && (flag_set == STATUS_RESET) |=> flags_reg == STATUS_RESET)
    else $error("flags not cleared by status read");
endmodule

//--- tb/kxs_col_src.sv
`timescale 1ns/1ps
module kxs_col_src (
  input  wire logic        mclk,       // core clock
  output      logic [31:0] xgmii_data, // column toward the block
  output      logic [3:0]  xgmii_ctrl, // control flag per lane
  output      logic [4:0]  events      // pattern err, rx ins, rx drop, tx ins, tx drop
);
  localparam logic [31:0] IDLE_COL = 32'hbcbcbcbc;

  initial begin
    xgmii_data = IDLE_COL;
    xgmii_ctrl = 4'hf;
    events     = 5'h00;
  end

  // one column, held for one cycle
  task automatic col(input logic [31:0] d, input logic [3:0] c);
    xgmii_data = d;
    xgmii_ctrl = c;
    @(negedge mclk);
  endtask

  // events high for n cycles, then one quiet cycle
  task automatic pulse(input logic [4:0] mask, input int n);
    events = mask;
    repeat (n) @(negedge mclk);
    events = 5'h00;
    @(negedge mclk);
  endtask
endmodule

//--- tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import kxs_pkg::*;

  typedef struct {
    logic [31:0] d0;
    logic [3:0]  k0;
    logic [31:0] d1;
    logic [3:0]  k1;
    logic [15:0] e2;
    logic [15:0] e3;
  } kxs_eop_case_type;

  logic             mclk;
  logic             resetn;
  logic             tx_pattern_sync;
  logic             mgmt_rd_en;
  logic [4:0]       mgmt_devad;
  logic [15:0]      mgmt_addr;
  logic [15:0]      mgmt_rdata;
  logic             mgmt_rvalid;
  logic [31:0]      xgmii_data;
  logic [3:0]       xgmii_ctrl;
  logic [4:0]       events;
  logic [15:0]      exp_tbl [9];
  kxs_eop_case_type eop_tbl [7];
  int               fail_count;
  int               samples_checked;

  kxs_col_src i_kxs_col_src (
    .mclk       (mclk),
    .xgmii_data (xgmii_data),
    .xgmii_ctrl (xgmii_ctrl),
    .events     (events)
  );

  kxs_error_stats i_kxs_error_stats (
    .mclk             (mclk),
    .resetn           (resetn),
    .xgmii_data       (xgmii_data),
    .xgmii_ctrl       (xgmii_ctrl),
    .tx_idle_drop     (events[0]),
    .tx_idle_insert   (events[1]),
    .rx_idle_drop     (events[2]),
    .rx_idle_insert   (events[3]),
    .tx_pattern_sync  (tx_pattern_sync),
    .tx_pattern_error (events[4]),
    .mgmt_rd_en       (mgmt_rd_en),
    .mgmt_devad       (mgmt_devad),
    .mgmt_addr        (mgmt_addr),
    .mgmt_rdata       (mgmt_rdata),
    .mgmt_rvalid      (mgmt_rvalid)
  );

  initial begin
    mclk = 1'b0;
    forever #25 mclk = ~mclk;
  end

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // read strobe for one cycle, answer expected one edge later
  task automatic rd(input logic [4:0] dev, input logic [15:0] addr, input logic [15:0] exp);
    int n;
    mgmt_rd_en = 1'b1;
    mgmt_devad = dev;
    mgmt_addr  = addr;
    @(negedge mclk);
    n = 0;
    while (mgmt_rvalid !== 1'b1 && n < 3) begin
      mgmt_rd_en = 1'b0;
      @(negedge mclk);
      n++;
    end
    if (n != 0) begin
      fail_count++;
      $display("BAD rvalid_delay expected 0 seen %0d", n);
      if (n == 3) finish_test();
    end
    chk($sformatf("reg_%h", addr), exp, mgmt_rdata);
    mgmt_rd_en = 1'b0;
    @(negedge mclk);
    chk("rvalid_low", 16'h0000, 16'(mgmt_rvalid));
  endtask

  initial begin
    resetn          = 1'b0;
    tx_pattern_sync = 1'b0;
    mgmt_rd_en      = 1'b0;
    mgmt_devad      = MGMT_DEVAD;
    mgmt_addr       = 16'h0000;
    fail_count      = 0;
    samples_checked = 0;
    exp_tbl = '{CNT_RESET, CNT_RESET, CNT_RESET, 16'hffff, CNT_RESET, CNT_RESET,
                STATUS_RESET, 16'hffff, 16'hffff};
    eop_tbl = '{
      '{32'hbcfd0304, 4'hc, 32'hbcbcbcbc, 4'hf, 16'h0000, 16'h0000},
      '{32'h55fd0304, 4'h4, 32'hbcbcbcbc, 4'hf, 16'h0001, 16'h0000},
      '{32'hbcfd0304, 4'hc, 32'h01020304, 4'h0, 16'h0001, 16'h0000},
      '{32'h55fd0304, 4'h4, 32'h01020304, 4'h0, 16'h0001, 16'h0000},
      '{32'hfd030201, 4'h8, 32'h7c7c7c7c, 4'hf, 16'h0000, 16'h0000},
      '{32'hfd030201, 4'h8, 32'h01020304, 4'h0, 16'h0000, 16'h0001},
      '{32'hfd030201, 4'h8, 32'hbcbc7c7c, 4'hf, 16'h0000, 16'h0001}};
    repeat (12) @(negedge mclk);
    resetn = 1'b1;
    repeat (3) @(negedge mclk);

    // three events on top of near-full reset values must stick at all-ones
    i_kxs_col_src.pulse(5'h12, 3); // saturation
    rd(5'h02, ADDR_TX_DROP, READ_ZERO); // wrong device refused
    rd(MGMT_DEVAD, 16'h801b, READ_ZERO); // unmapped refused
    for (int i = 0; i < 9; i++) begin
      rd(MGMT_DEVAD, ADDR_LANE2_EOP + 16'(i), exp_tbl[i]);
    end
    for (int i = 0; i < 9; i++) begin
      rd(MGMT_DEVAD, ADDR_LANE2_EOP + 16'(i), READ_ZERO); // clear on read
    end
    $display("test reset_values done");

    for (int i = 0; i < 4; i++) begin
      i_kxs_col_src.pulse(5'(1 << i), i + 1);
      rd(MGMT_DEVAD, ADDR_TX_DROP + 16'(i), 16'(i + 1)); // event counts
    end
    fork
      i_kxs_col_src.pulse(5'h02, 1);
      rd(MGMT_DEVAD, ADDR_TX_INS, READ_ZERO); // event during read
    join
    rd(MGMT_DEVAD, ADDR_TX_INS, 16'h0001); // event kept after clear
    i_kxs_col_src.pulse(5'h10, 2);
    rd(MGMT_DEVAD, ADDR_PAT_HIGH, READ_ZERO); // upper half
    rd(MGMT_DEVAD, ADDR_PAT_LOW, 16'h0002); // lower half
    $display("test event_counts done");

    for (int i = 0; i < 7; i++) begin
      i_kxs_col_src.col(eop_tbl[i].d0, eop_tbl[i].k0);
      i_kxs_col_src.col(eop_tbl[i].d1, eop_tbl[i].k1);
      i_kxs_col_src.col(32'hbcbcbcbc, 4'hf);
      rd(MGMT_DEVAD, ADDR_LANE2_EOP, eop_tbl[i].e2); // lane 2 end errors
      rd(MGMT_DEVAD, ADDR_LANE3_EOP, eop_tbl[i].e3); // lane 3 end errors
    end
    $display("test packet_end done");

    tx_pattern_sync = 1'b1;
    rd(MGMT_DEVAD, ADDR_STATUS, 16'h8000); // sync shown
    i_kxs_col_src.col(32'h0707fb07, 4'hf);
    i_kxs_col_src.col(32'hbcbcbcbc, 4'hf);
    rd(MGMT_DEVAD, ADDR_STATUS, 16'h8020); // bad start column
    rd(MGMT_DEVAD, ADDR_STATUS, 16'h8000); // flag cleared by read
    i_kxs_col_src.col(32'h0707fdfd, 4'hf);
    i_kxs_col_src.col(32'hbcbcbcbc, 4'hf);
    rd(MGMT_DEVAD, ADDR_STATUS, 16'h8010); // bad terminate column
    for (int i = 0; i < 4; i++) begin
      i_kxs_col_src.col((32'hbcbcbcbc & ~(32'hff << (8 * i))) | (32'h55 << (8 * i)), 4'hf);
      i_kxs_col_src.col(32'hbcbcbcbc, 4'hf);
      rd(MGMT_DEVAD, ADDR_STATUS, 16'h8000 | 16'(1 << i)); // per-lane bad character
    end
    tx_pattern_sync = 1'b0;
    rd(MGMT_DEVAD, ADDR_STATUS, STATUS_RESET); // sync lost
    $display("test status done");
    finish_test();
  end
endmodule
